// ---- core/mcg_consts.svh ----
// Purpose: constants of the global machine-check registers
// Assumes: register index space, one 64-bit word per index
// Notes:   offsets are register indices
`ifndef MCG_CONSTS_SVH
`define MCG_CONSTS_SVH

`define MCG_IDX_CAPABILITY     12'h179
`define MCG_IDX_GLOBAL_STATUS  12'h17A
`define MCG_IDX_GLOBAL_CONTROL 12'h17B
`define MCG_CAP_COUNT_LSB      0
`define MCG_CAP_COUNT_MSB      7
`define MCG_CAP_CTL_PRESENT    8
`define MCG_STS_RESTART        0
`define MCG_STS_ERROR_PTR      1
`define MCG_STS_IN_PROGRESS    2
`define MCG_STATUS_RESET       64'h0000_0000_0000_0000
`define MCG_CONTROL_RESET      64'hFFFF_FFFF_FFFF_FFFF
`define MCG_CHECK_STREAM_DEPTH 1

`endif

// ---- core/mcg_global_regs.sv ----
// Purpose: per-core global machine-check registers
// Assumes: register port with one-cycle strobes, read data next cycle
// Notes:   registers sit at their indices; unmapped reads return zero
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mcg_consts.svh"

////////////////////////////////////////////////////////////////////////
// Function
// RQ1 - capability bits 7:0 give the read-only count of error banks
// RQ2 - capability bit 8 shows whether the global control register exists
// RQ3 - status bit 0 set when saved pointer allows a restart
// RQ4 - status bit 1 set when saved pointer is tied to the error
// RQ5 - status bit 2 set whenever a machine check is generated
// RQ6 - check while bit 2 still set enters shutdown instead
// RQ7 - software writes bit 2 to zero after handling the check
// RQ8 - pointer bits update in the same cycle that bit 2 is set
module mcg_global_regs #(
    parameter logic [7:0] BANK_COUNT  = 8'h05,
    parameter bit         HAS_CONTROL = 1'b1
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic [11:0]       i_addr,
    input  wire logic [63:0]       i_wr_data,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic              i_check,
    input  wire logic              i_restart_ok,
    input  wire logic              i_error_tied,
    output logic      [63:0]       o_rd_data,
    output logic                   o_raise_check,
    output logic                   o_shutdown,
    output logic      [63:0]       o_global_control,
    output logic                   o_check_in_progress
);
    ////////////////////////////////////////////////////////////////////
    // decode and check qualification
    mcg_pkg::mcg_state_t state;
    mcg_pkg::mcg_state_t next_state;
    logic                wr_status;
    logic                wr_control;
    logic                take_check;
    logic                restart_pv;
    logic                error_pv;
    logic                in_progress;
    mcg_pkg::mcg_word_t  capability;
    mcg_pkg::mcg_word_t  status_word;
    mcg_pkg::mcg_word_t  next_rd_data;

    assign wr_status  = i_wr && (i_addr == `MCG_IDX_GLOBAL_STATUS);
    assign wr_control = i_wr && HAS_CONTROL
                        && (i_addr == `MCG_IDX_GLOBAL_CONTROL);
    // a check is only taken while none is pending and not shut down
    assign take_check = i_check && !in_progress && !o_shutdown
                        && (state != mcg_pkg::MCG_SHUTDOWN); // RQ6

    always_comb begin
        capability = 64'h0;
        capability[`MCG_CAP_COUNT_MSB:`MCG_CAP_COUNT_LSB] = BANK_COUNT; // RQ1
        capability[`MCG_CAP_CTL_PRESENT] = HAS_CONTROL; // RQ2
    end

    ////////////////////////////////////////////////////////////////////
    // status bits
    mcg_status_bits u_mcg_status_bits (
        .i_clk                   (i_clk),
        .i_reset                 (i_reset),
        .i_check                 (take_check),
        .i_restart_ok            (i_restart_ok),
        .i_error_tied            (i_error_tied),
        .i_wr                    (wr_status),
        .i_wr_data               (i_wr_data[2:0]),
        .o_restart_pointer_valid (restart_pv),
        .o_error_pointer_valid   (error_pv),
        .o_check_in_progress     (in_progress)
    );

    ////////////////////////////////////////////////////////////////////
    // handling state
    always_comb begin
        next_state = state;
        case (state)
            mcg_pkg::MCG_IDLE: begin
                if (i_check && in_progress) begin
                    next_state = mcg_pkg::MCG_SHUTDOWN; // RQ6
                end else if (take_check) begin
                    next_state = mcg_pkg::MCG_HANDLING;
                end
            end
            mcg_pkg::MCG_HANDLING: begin
                if (i_check && in_progress) begin
                    next_state = mcg_pkg::MCG_SHUTDOWN; // RQ6
                end else if (!in_progress) begin
                    next_state = mcg_pkg::MCG_IDLE;
                end
            end
            mcg_pkg::MCG_SHUTDOWN: begin
                next_state = mcg_pkg::MCG_SHUTDOWN;
            end
            default: begin
                next_state = mcg_pkg::MCG_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= mcg_pkg::MCG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_raise_check <= 1'b0;
            o_shutdown    <= 1'b0;
        end else begin
            o_raise_check <= take_check; // RQ5
            o_shutdown    <= o_shutdown
                             || (i_check && in_progress); // RQ6
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_global_control <= `MCG_CONTROL_RESET;
        end else if (wr_control) begin
            o_global_control <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_check_in_progress <= 1'b0;
        end else begin
            o_check_in_progress <= take_check || (wr_status
                ? i_wr_data[`MCG_STS_IN_PROGRESS] : in_progress); // RQ5
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read
    always_comb begin
        status_word = 64'h0;
        status_word[`MCG_STS_RESTART]     = restart_pv; // RQ3
        status_word[`MCG_STS_ERROR_PTR]   = error_pv; // RQ4
        status_word[`MCG_STS_IN_PROGRESS] = in_progress; // RQ5
    end

    always_comb begin
        next_rd_data = 64'h0;
        if (i_rd) begin
            case (i_addr)
                `MCG_IDX_CAPABILITY: begin
                    next_rd_data = capability;
                end
                `MCG_IDX_GLOBAL_STATUS: begin
                    next_rd_data = status_word;
                end
                `MCG_IDX_GLOBAL_CONTROL: begin
                    if (HAS_CONTROL) begin
                        next_rd_data = o_global_control;
                    end
                end
                default: begin
                    next_rd_data = 64'h0;
                end
            endcase
        end
    end

    // read data stand for the one cycle after the strobe only
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rd_data <= 64'h0;
        end else begin
            o_rd_data <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_cap_count_read : assert property (@(posedge i_clk) // RQ1
        disable iff (i_reset) (i_rd && i_addr == `MCG_IDX_CAPABILITY)
        |=> o_rd_data[7:0] == BANK_COUNT)
        else $error("capability count wrong");

    a_cap_ctl_bit : assert property (@(posedge i_clk) // RQ2
        disable iff (i_reset) (i_rd && i_addr == `MCG_IDX_CAPABILITY)
        |=> o_rd_data[8] == HAS_CONTROL && o_rd_data[63:9] == 55'h0)
        else $error("capability control bit wrong");

    a_restart_bit_read : assert property (@(posedge i_clk) // RQ3
        disable iff (i_reset) (take_check && !i_rd) ##1
        (i_rd && i_addr == `MCG_IDX_GLOBAL_STATUS && !i_wr)
        |=> o_rd_data[0] == $past(i_restart_ok, 2))
        else $error("restart bit not reported");

    a_error_bit_read : assert property (@(posedge i_clk) // RQ4
        disable iff (i_reset) (take_check && !i_rd) ##1
        (i_rd && i_addr == `MCG_IDX_GLOBAL_STATUS && !i_wr)
        |=> o_rd_data[1] == $past(i_error_tied, 2))
        else $error("error pointer bit not reported");

    a_check_raises : assert property (@(posedge i_clk) // RQ5
        disable iff (i_reset) take_check
        |=> o_raise_check && o_check_in_progress)
        else $error("check not raised");

    a_flag_mirror : assert property (@(posedge i_clk) // RQ5
        disable iff (i_reset) o_check_in_progress == in_progress)
        else $error("in-progress output differs from status");

    a_status_flag_read : assert property (@(posedge i_clk) // RQ5
        disable iff (i_reset) (i_rd && i_addr == `MCG_IDX_GLOBAL_STATUS)
        |=> o_rd_data[2] == $past(o_check_in_progress))
        else $error("in-progress bit not reported");

    a_raise_pulse : assert property (@(posedge i_clk) // RQ5
        disable iff (i_reset) o_raise_check |=> !o_raise_check)
        else $error("raise longer than one cycle");

    a_raise_cause : assert property (@(posedge i_clk) // RQ5
        disable iff (i_reset) o_raise_check
        |-> $past(i_check) && !$past(o_shutdown))
        else $error("raise without a check");

    a_second_shutdown : assert property (@(posedge i_clk) // RQ6
        disable iff (i_reset) (i_check && in_progress)
        |=> o_shutdown && !o_raise_check)
        else $error("second check did not shut down");

    a_shutdown_sticky : assert property (@(posedge i_clk) // RQ6
        disable iff (i_reset) o_shutdown |=> o_shutdown)
        else $error("shutdown left without reset");

    a_shut_no_raise : assert property (@(posedge i_clk) // RQ6
        disable iff (i_reset) o_shutdown |-> !o_raise_check)
        else $error("check raised in shutdown");

    a_shut_ignores : assert property (@(posedge i_clk) // RQ6
        disable iff (i_reset) (i_check && o_shutdown) |=> !o_raise_check)
        else $error("check taken after shutdown");

    a_shutdown_state : assert property (@(posedge i_clk) // RQ6
        disable iff (i_reset) o_shutdown |-> state == mcg_pkg::MCG_SHUTDOWN)
        else $error("shutdown flag without shutdown state");

    a_clear_allows : assert property (@(posedge i_clk) // RQ7
        disable iff (i_reset) (wr_status
        && !i_wr_data[`MCG_STS_IN_PROGRESS] && !i_check && !o_shutdown)
        |=> !o_check_in_progress && !in_progress)
        else $error("in-progress not cleared by write");

    a_same_cycle : assert property (@(posedge i_clk) // RQ8
        disable iff (i_reset) $rose(o_raise_check)
        |-> in_progress && restart_pv == $past(i_restart_ok))
        else $error("status bits not set with check");

    a_pointer_hold : assert property (@(posedge i_clk) // RQ8
        disable iff (i_reset) (!take_check && !wr_status)
        |=> $stable(restart_pv) && $stable(error_pv))
        else $error("pointer bits changed without cause");

    a_ptr_write : assert property (@(posedge i_clk) // RQ3
        disable iff (i_reset) (wr_status && !take_check)
        |=> restart_pv == $past(i_wr_data[`MCG_STS_RESTART])
        && error_pv == $past(i_wr_data[`MCG_STS_ERROR_PTR]))
        else $error("pointer bits not written");

    a_status_upper : assert property (@(posedge i_clk)
        disable iff (i_reset) (i_rd && i_addr == `MCG_IDX_GLOBAL_STATUS)
        |=> o_rd_data[63:3] == 61'h0)
        else $error("status reserved bits not zero");

    a_unmapped_zero : assert property (@(posedge i_clk)
        disable iff (i_reset) (i_rd && i_addr != `MCG_IDX_CAPABILITY
        && i_addr != `MCG_IDX_GLOBAL_STATUS
        && i_addr != `MCG_IDX_GLOBAL_CONTROL) |=> o_rd_data == 64'h0)
        else $error("unmapped read not zero");

    a_rd_idle_zero : assert property (@(posedge i_clk)
        disable iff (i_reset) !i_rd |=> o_rd_data == 64'h0)
        else $error("read data outside read cycle");

    a_control_write : assert property (@(posedge i_clk) // RQ2
        disable iff (i_reset) wr_control
        |=> o_global_control == $past(i_wr_data))
        else $error("control write not stored");

    a_control_hold : assert property (@(posedge i_clk) // RQ2
        disable iff (i_reset) !wr_control |=> $stable(o_global_control))
        else $error("control changed without write");

    c_first_check : cover property (@(posedge i_clk) take_check);
    c_shutdown : cover property (@(posedge i_clk) $rose(o_shutdown));
    c_cleared : cover property (@(posedge i_clk)
        $fell(o_check_in_progress));
    c_control_write : cover property (@(posedge i_clk) wr_control);
    c_check_beats_clear : cover property (@(posedge i_clk)
        take_check && wr_status);
endmodule : mcg_global_regs
`default_nettype wire

// ---- core/mcg_pkg.sv ----
// Purpose: shared types of the global machine-check registers
// Assumes: nothing
// Notes:   register data are 64 bits wide
package mcg_pkg;
    typedef logic [63:0] mcg_word_t;
    typedef logic [11:0] mcg_index_t;
    typedef enum logic [1:0] {
        MCG_IDLE     = 2'b00,
        MCG_HANDLING = 2'b01,
        MCG_SHUTDOWN = 2'b10
    } mcg_state_t;
endpackage : mcg_pkg

// ---- core/mcg_status_bits.sv ----
// Purpose: pointer-validity and in-progress bits of the global status
// Assumes: check event and qualifiers come from the same clock
// Notes:   hardware set wins over software write
`timescale 1ns/1ps
`default_nettype none
`include "mcg_consts.svh"

module mcg_status_bits (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_check,
    input  wire logic       i_restart_ok,
    input  wire logic       i_error_tied,
    input  wire logic       i_wr,
    input  wire logic [2:0] i_wr_data,
    output logic            o_restart_pointer_valid,
    output logic            o_error_pointer_valid,
    output logic            o_check_in_progress
);
    // pointer bits follow each accepted check
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_restart_pointer_valid <= 1'b0;
            o_error_pointer_valid   <= 1'b0;
        end else if (i_check) begin
            o_restart_pointer_valid <= i_restart_ok; // RQ3 RQ8
            o_error_pointer_valid   <= i_error_tied; // RQ4 RQ8
        end else if (i_wr) begin
            o_restart_pointer_valid <= i_wr_data[`MCG_STS_RESTART];
            o_error_pointer_valid   <= i_wr_data[`MCG_STS_ERROR_PTR];
        end
    end

    // in-progress flag; a check beats a clearing write
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_check_in_progress <= 1'b0;
        end else if (i_check) begin
            o_check_in_progress <= 1'b1; // RQ5 RQ8
        end else if (i_wr) begin
            o_check_in_progress <= i_wr_data[`MCG_STS_IN_PROGRESS]; // RQ7
        end
    end

    a_check_sets_flag : assert property (@(posedge i_clk) // RQ5
        disable iff (i_reset) i_check |=> o_check_in_progress)
        else $error("in-progress not set after check");
    a_pointers_follow : assert property (@(posedge i_clk) // RQ8
        disable iff (i_reset) i_check |=>
        (o_restart_pointer_valid == $past(i_restart_ok)
         && o_error_pointer_valid == $past(i_error_tied)))
        else $error("pointer bits not captured with check");
endmodule : mcg_status_bits
`default_nettype wire

// ---- test/mcg_global_regs_test.sv ----
// Purpose: self-checking bench for the global machine-check registers
// Assumes: register port with one-cycle strobes, read data next cycle
// Notes:   ports driven by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none

module mcg_global_regs_test;
    localparam logic [7:0] BANKS = 8'h05;
    localparam bit         CTL   = 1'b1;

    logic        i_clk;
    logic        i_reset;
    logic [11:0] i_addr;
    logic [63:0] i_wr_data;
    logic        i_wr;
    logic        i_rd;
    logic        i_check;
    logic        i_restart_ok;
    logic        i_error_tied;
    logic [63:0] o_rd_data;
    logic        o_raise_check;
    logic        o_shutdown;
    logic [63:0] o_global_control;
    logic        o_check_in_progress;
    int          bad_count;
    int          n_checks;
    int          cycles;
    logic [63:0] rd;

    mcg_global_regs #(
        .BANK_COUNT  (BANKS),
        .HAS_CONTROL (CTL)
    ) u_mcg_global_regs (
        .i_clk               (i_clk),
        .i_reset             (i_reset),
        .i_addr              (i_addr),
        .i_wr_data           (i_wr_data),
        .i_wr                (i_wr),
        .i_rd                (i_rd),
        .i_check             (i_check),
        .i_restart_ok        (i_restart_ok),
        .i_error_tied        (i_error_tied),
        .o_rd_data           (o_rd_data),
        .o_raise_check       (o_raise_check),
        .o_shutdown          (o_shutdown),
        .o_global_control    (o_global_control),
        .o_check_in_progress (o_check_in_progress)
    );

    ////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare and bus tasks
    task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic reg_read(input logic [11:0] a, output logic [63:0] d);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rd_data;
    endtask : reg_read

    task automatic reg_write(input logic [11:0] a, input logic [63:0] d);
        @(posedge i_clk);
        i_wr      <= 1'b1;
        i_addr    <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic fire_check(input logic r, input logic e);
        @(posedge i_clk);
        i_check      <= 1'b1;
        i_restart_ok <= r;
        i_error_tied <= e;
        @(posedge i_clk);
        i_check <= 1'b0;
        #1;
    endtask : fire_check

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_capability;
        cmp_bit(o_shutdown, 1'b0);
        cmp_word(o_global_control, 64'hFFFF_FFFF_FFFF_FFFF);
        reg_read(12'h179, rd);
        cmp_word(rd, {55'h0, CTL, BANKS});
        reg_write(12'h179, 64'hFFFF_FFFF_FFFF_FFFF);
        reg_read(12'h179, rd);
        cmp_word(rd, {55'h0, CTL, BANKS});
        reg_read(12'h100, rd);
        cmp_word(rd, 64'h0);
    endtask : t_capability

    task automatic t_control;
        reg_write(12'h17B, 64'h0123_4567_89AB_CDEF);
        cmp_word(o_global_control, 64'h0123_4567_89AB_CDEF);
        reg_read(12'h17B, rd);
        cmp_word(rd, 64'h0123_4567_89AB_CDEF);
        reg_write(12'h17A, 64'hFFFF_FFFF_FFFF_FFFB);
        reg_read(12'h17A, rd);
        cmp_word(rd, 64'h3);
    endtask : t_control

    task automatic t_first_check;
        fire_check(1'b1, 1'b0);
        cmp_bit(o_raise_check, 1'b1);
        cmp_bit(o_check_in_progress, 1'b1);
        @(posedge i_clk);
        #1;
        cmp_bit(o_raise_check, 1'b0);
        reg_read(12'h17A, rd);
        cmp_word(rd, 64'h5);
    endtask : t_first_check

    task automatic t_clear;
        reg_write(12'h17A, 64'h0);
        cmp_bit(o_check_in_progress, 1'b0);
        reg_read(12'h17A, rd);
        cmp_word(rd, 64'h0);
    endtask : t_clear

    task automatic t_collide;
        @(posedge i_clk);
        i_check      <= 1'b1;
        i_restart_ok <= 1'b1;
        i_error_tied <= 1'b1;
        i_wr         <= 1'b1;
        i_addr       <= 12'h17A;
        i_wr_data    <= 64'h0;
        @(posedge i_clk);
        i_check <= 1'b0;
        i_wr    <= 1'b0;
        i_rd    <= 1'b1;
        #1;
        cmp_bit(o_raise_check, 1'b1);
        cmp_bit(o_check_in_progress, 1'b1);
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        cmp_word(o_rd_data, 64'h7);
        reg_write(12'h17A, 64'h0);
        cmp_bit(o_check_in_progress, 1'b0);
    endtask : t_collide

    task automatic t_error_ptr;
        fire_check(1'b0, 1'b1);
        cmp_bit(o_raise_check, 1'b1);
        reg_read(12'h17A, rd);
        cmp_word(rd, 64'h6);
        cmp_bit(o_shutdown, 1'b0);
    endtask : t_error_ptr

    task automatic t_shutdown;
        fire_check(1'b1, 1'b1);
        cmp_bit(o_shutdown, 1'b1);
        cmp_bit(o_raise_check, 1'b0);
        repeat (3) @(posedge i_clk);
        #1;
        cmp_bit(o_shutdown, 1'b1);
        fire_check(1'b1, 1'b0);
        cmp_bit(o_raise_check, 1'b0);
    endtask : t_shutdown

    task automatic t_reset_again;
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        cmp_bit(o_shutdown, 1'b0);
        cmp_bit(o_check_in_progress, 1'b0);
        cmp_word(o_global_control, 64'hFFFF_FFFF_FFFF_FFFF);
        fire_check(1'b1, 1'b1);
        cmp_bit(o_raise_check, 1'b1);
        reg_read(12'h17A, rd);
        cmp_word(rd, 64'h7);
    endtask : t_reset_again

    ////////////////////////////////////////////////////////////////////
    // verdict
    task automatic results;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        bad_count    = 0;
        n_checks     = 0;
        cycles       = 0;
        i_reset      = 1'b1;
        i_addr       = 12'h000;
        i_wr_data    = 64'h0;
        i_wr         = 1'b0;
        i_rd         = 1'b0;
        i_check      = 1'b0;
        i_restart_ok = 1'b0;
        i_error_tied = 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        t_capability();
        t_control();
        t_first_check();
        t_clear();
        t_collide();
        t_error_ptr();
        t_shutdown();
        t_reset_again();
        results();
    end
endmodule : mcg_global_regs_test

`default_nettype wire
